// ==== hw/faxdw_pkg.sv ====
// faxdw_pkg: address map, watchdog and reset timing of the fax address decoder.
// assumes a single 200 MHz system clock and a 16-bit CPU address bus.
package faxdw_pkg;

  // clock rate
  localparam int CLK_MHZ = 200;
  localparam int CLK_KHZ = 200000;

  // program flash map
  localparam logic [15:0] FLASH_COMMON_LO = 16'h0000;
  localparam logic [15:0] FLASH_COMMON_HI = 16'h7FFF;
  localparam logic [15:0] FLASH_BANK_LO   = 16'h8000;
  localparam logic [15:0] FLASH_BANK_HI   = 16'h9FFF;
  localparam int          FLASH_AW        = 19;     // 512KB part
  localparam int          BANK_W          = 6;      // 64 banks of 8KB
  localparam int          BANK_OFS_W      = 13;     // 8KB window offset
  localparam int          COMMON_OFS_W    = 15;     // 32KB common area
  localparam logic [5:0]  BANK_FIRST      = 6'h04;  // lowest switchable bank
  localparam logic [5:0]  BANK_LAST       = 6'h3F;  // highest switchable bank

  // work DRAM windows
  localparam logic [15:0] DRAM_WIN1_LO = 16'hF200;
  localparam logic [15:0] DRAM_WIN1_HI = 16'hF3FF;
  localparam logic [15:0] DRAM_WIN2_LO = 16'hF600;
  localparam logic [15:0] DRAM_WIN2_HI = 16'hF7FF;
  localparam int          DRAM_OFS_W   = 9;      // 512 bytes per window
  localparam int          DRAM_AW      = 10;     // window bit plus offset

  // internal image work memory, 8 KB
  localparam int IMG_AW    = 13;
  localparam int IMG_DEPTH = 8192;

  // watchdog: serviced about every 1.5 ms, expires after WDOG_TIMEOUT_US
  localparam int WDOG_SERVICE_US  = 1500;
  localparam int WDOG_TIMEOUT_US  = 3000;
  localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_US * CLK_MHZ;
  localparam int WDOG_FAULT_US    = 10;
  localparam int WDOG_FAULT_CYC   = WDOG_FAULT_US * CLK_MHZ;
  localparam int WDOG_CNT_W       = 20;

  // power-fail reset pulse, 60 ms
  localparam int PWR_RST_MS  = 60;
  localparam int PWR_RST_CYC = PWR_RST_MS * CLK_KHZ;
  localparam int PWR_CNT_W   = 24;

endpackage

// ==== hw/faxdw_decoder_watchdog.sv ====
// faxdw_decoder_watchdog: CPU address decoder, flash bank window, DRAM windows,
// image work memory, watchdog and power-fail reset pulse generator.
// assumes CPU strobes and bank index come from logic on clk_sys; the power-fail
// pin is asynchronous and is synchronised here.
// Behaviour
// - accesses 0000H-7FFFH select the fixed 32KB common flash area.
// - accesses 8000H-9FFFH select the current flash bank, bank forms the address.
// - 512KB flash in 8KB banks; banks 4 to 63 may appear in the window.
// - accesses F200H-F3FFH select the DRAM, first window.
// - accesses F600H-F7FFH select the DRAM, second window.
// - chip selects come from the decoded address; the bank index is supplied from outside.
// - an internal 8KB image work memory is provided.
// - an unserviced watchdog drives its fault output low.
// - a low watchdog fault acts as the system reset.
// - a power interruption gives a 60 ms positive reset pulse.
`timescale 1ns/1ps
module faxdw_decoder_watchdog #(
  parameter logic [faxdw_pkg::WDOG_CNT_W-1:0] WDOG_TIMEOUT =
    faxdw_pkg::WDOG_CNT_W'(faxdw_pkg::WDOG_TIMEOUT_CYC),
  parameter logic [faxdw_pkg::WDOG_CNT_W-1:0] WDOG_FAULT_LEN =
    faxdw_pkg::WDOG_CNT_W'(faxdw_pkg::WDOG_FAULT_CYC),
  parameter logic [faxdw_pkg::PWR_CNT_W-1:0]  PWR_RST_LEN =
    faxdw_pkg::PWR_CNT_W'(faxdw_pkg::PWR_RST_CYC)
) (
  input  wire logic                              clk_sys,
  input  wire logic                              rstn,
  input  wire logic [15:0]                       cpuAddr,
  input  wire logic                              cpuMreq,
  input  wire logic [faxdw_pkg::BANK_W-1:0]      flashBankIndex,
  input  wire logic                              wdogKick,
  input  wire logic                              pwrFail,
  input  wire logic [faxdw_pkg::IMG_AW-1:0]      imgAddr,
  input  wire logic                              imgWe,
  input  wire logic [7:0]                        imgWdata,
  output logic                                   flashSelN,
  output logic [faxdw_pkg::FLASH_AW-1:0]         flashAddr,
  output logic                                   dramSelN,
  output logic [faxdw_pkg::DRAM_AW-1:0]          dramAddr,
  output logic [7:0]                             imgRdata,
  output logic                                   watchdogFaultOutN,
  output logic                                   sysResetOut
);
  import faxdw_pkg::*;

  logic                  rstMeta;
  logic                  rstSyncN;
  logic                  pwrMeta;
  logic                  pwrSync;
  logic                  pwrLast;
  logic                  pwrEdge;
  logic [PWR_CNT_W-1:0]  pwrCnt;
  logic                  pwrActive;
  logic [WDOG_CNT_W-1:0] wdogCnt;
  logic [WDOG_CNT_W-1:0] faultCnt;
  logic                  faultActive;
  logic                  wdogExpire;
  logic                  sysHold;
  logic                  inCommon;
  logic                  inBank;
  logic                  bankOk;
  logic                  inWin1;
  logic                  inWin2;
  logic                  next_flashSelN;
  logic [FLASH_AW-1:0]   next_flashAddr;
  logic                  next_dramSelN;
  logic [DRAM_AW-1:0]    next_dramAddr;
  logic [7:0]            imgMem [IMG_DEPTH];

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // power-fail pin synchroniser; edge taken from the second and third flop only
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pwrMeta <= 1'b0;
      pwrSync <= 1'b0;
      pwrLast <= 1'b0;
    end else begin
      pwrMeta <= pwrFail;
      pwrSync <= pwrMeta;
      pwrLast <= pwrSync;
    end
  end

  assign pwrEdge = pwrSync && !pwrLast;

  // 60 ms pulse: a new interruption during the pulse restarts it
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pwrCnt    <= '0;
      pwrActive <= 1'b0;
    end else if (pwrEdge) begin
      pwrCnt    <= PWR_RST_LEN - PWR_CNT_W'(1);
      pwrActive <= 1'b1;
    end else if (pwrCnt != '0) begin
      pwrCnt <= pwrCnt - PWR_CNT_W'(1);
    end else begin
      pwrActive <= 1'b0;
    end
  end

  // positive reset output straight from a flop
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sysResetOut <= 1'b0;
    end else begin
      sysResetOut <= pwrEdge || (pwrActive && pwrCnt != '0);
    end
  end

  // the decoder selects and the watchdog, not the image memory, are held while either reset source acts
  assign sysHold    = pwrActive || faultActive;
  assign wdogExpire = (wdogCnt == WDOG_TIMEOUT - WDOG_CNT_W'(1)) && !wdogKick;

  // watchdog count: firmware kick restarts it, reset holds it at zero
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wdogCnt <= '0;
    end else if (sysHold || wdogKick || wdogExpire) begin
      wdogCnt <= '0;
    end else begin
      wdogCnt <= wdogCnt + WDOG_CNT_W'(1);
    end
  end

  // fault pulse: low for WDOG_FAULT_LEN cycles so the reset line settles
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      faultCnt    <= '0;
      faultActive <= 1'b0;
    end else if (wdogExpire && !sysHold) begin
      faultCnt    <= WDOG_FAULT_LEN - WDOG_CNT_W'(1);
      faultActive <= 1'b1;
    end else if (faultCnt != '0) begin
      faultCnt <= faultCnt - WDOG_CNT_W'(1);
    end else begin
      faultActive <= 1'b0;
    end
  end

  // fault output, active low, from a flop
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      watchdogFaultOutN <= 1'b1;
    end else begin
      watchdogFaultOutN <= !((wdogExpire && !sysHold) || (faultActive && faultCnt != '0));
    end
  end

  // address range compare
  assign inCommon = cpuAddr <= FLASH_COMMON_HI;
  assign inBank   = (cpuAddr >= FLASH_BANK_LO) && (cpuAddr <= FLASH_BANK_HI);
  assign bankOk   = (flashBankIndex >= BANK_FIRST) && (flashBankIndex <= BANK_LAST);
  assign inWin1   = (cpuAddr >= DRAM_WIN1_LO) && (cpuAddr <= DRAM_WIN1_HI);
  assign inWin2   = (cpuAddr >= DRAM_WIN2_LO) && (cpuAddr <= DRAM_WIN2_HI);

  // next select and physical address; a bank below 4 would alias the common area
  always_comb begin
    next_flashSelN = 1'b1;
    next_flashAddr = '0;
    next_dramSelN  = 1'b1;
    next_dramAddr  = '0;
    if (cpuMreq && !sysHold) begin
      if (inCommon) begin
        next_flashSelN = 1'b0;
        next_flashAddr = {4'h0, cpuAddr[COMMON_OFS_W-1:0]};
      end
      if (inBank && bankOk) begin
        next_flashSelN = 1'b0;
        next_flashAddr = {flashBankIndex, cpuAddr[BANK_OFS_W-1:0]};
      end
      if (inWin1) begin
        next_dramSelN = 1'b0;
        next_dramAddr = {1'b0, cpuAddr[DRAM_OFS_W-1:0]};
      end
      if (inWin2) begin
        next_dramSelN = 1'b0;
        next_dramAddr = {1'b1, cpuAddr[DRAM_OFS_W-1:0]};
      end
    end
  end

  // registered chip selects; reset source blocks every select
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      flashSelN <= 1'b1;
      flashAddr <= '0;
      dramSelN  <= 1'b1;
      dramAddr  <= '0;
    end else begin
      flashSelN <= next_flashSelN;
      flashAddr <= next_flashAddr;
      dramSelN  <= next_dramSelN;
      dramAddr  <= next_dramAddr;
    end
  end

  // image work memory in flops; contents survive reset, so no reset branch
  always_ff @(posedge clk_sys) begin
    if (imgWe) begin
      imgMem[imgAddr] <= imgWdata;
    end
  end

  // registered read port, one cycle latency
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      imgRdata <= 8'h00;
    end else begin
      imgRdata <= imgMem[imgAddr];
    end
  end

  // helper for the memory check
  logic [IMG_AW-1:0] lastWrAddr;
  logic [7:0]        lastWrData;
  logic              lastWrValid;
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lastWrAddr  <= '0;
      lastWrData  <= 8'h00;
      lastWrValid <= 1'b0;
    end else if (imgWe) begin
      lastWrAddr  <= imgAddr;
      lastWrData  <= imgWdata;
      lastWrValid <= 1'b1;
    end
  end

  // helper: length of the current reset pulse; a restart begins a fresh count
  logic [PWR_CNT_W-1:0] pulseLen;
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pulseLen <= '0;
    end else if (pwrEdge) begin
      pulseLen <= '0;
    end else if (sysResetOut) begin
      pulseLen <= pulseLen + PWR_CNT_W'(1);
    end else begin
      pulseLen <= '0;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstSyncN);

  sequence sCpuCommon;
    cpuMreq && !sysHold && inCommon;
  endsequence

  sequence sCpuBank;
    cpuMreq && !sysHold && inBank && bankOk;
  endsequence

  sequence sPwrRise;
    !pwrSync ##1 pwrSync;
  endsequence

  AST_COMMON_FLASH: assert property (sCpuCommon |=> !flashSelN && dramSelN
    && flashAddr == {4'h0, $past(cpuAddr[COMMON_OFS_W-1:0])})
    else $error("common area access not mapped to flash");

  AST_BANK_FLASH: assert property (sCpuBank |=> !flashSelN
    && flashAddr == {$past(flashBankIndex), $past(cpuAddr[BANK_OFS_W-1:0])})
    else $error("bank window address wrong");

  AST_BANK_RANGE: assert property (cpuMreq && inBank && !bankOk
    |=> flashSelN)
    else $error("bank below 4 selected flash");

  AST_DRAM_WIN1: assert property (cpuMreq && !sysHold && inWin1
    |=> !dramSelN && flashSelN && dramAddr == {1'b0, $past(cpuAddr[DRAM_OFS_W-1:0])})
    else $error("dram window 1 not selected");

  AST_DRAM_WIN2: assert property (cpuMreq && !sysHold && inWin2
    |=> !dramSelN && flashSelN && dramAddr == {1'b1, $past(cpuAddr[DRAM_OFS_W-1:0])})
    else $error("dram window 2 not selected");

  AST_UNMAPPED: assert property (!(inCommon || inBank || inWin1 || inWin2)
    |=> flashSelN && dramSelN)
    else $error("unmapped address raised a select");

  AST_ONE_SELECT: assert property (!(~flashSelN && ~dramSelN))
    else $error("flash and dram selected together");

  AST_IMG_READBACK: assert property (lastWrValid && !imgWe
    && imgAddr == lastWrAddr |=> imgRdata == $past(lastWrData))
    else $error("image memory read mismatch");

  AST_WDOG_KICK: assert property (wdogKick && !sysHold
    |=> wdogCnt == '0 ##1 watchdogFaultOutN)
    else $error("kick did not restart watchdog");

  AST_WDOG_FAULT: assert property (wdogExpire && !sysHold
    |=> !watchdogFaultOutN [*2])
    else $error("expired watchdog left fault high");

  AST_FAULT_RESETS: assert property (!watchdogFaultOutN
    |=> flashSelN && dramSelN && wdogCnt == '0)
    else $error("fault did not reset the system");

  AST_PWR_PULSE: assert property (sPwrRise |=> sysResetOut [*4])
    else $error("power-fail pulse missing");

  AST_PWR_LEN: assert property (sysResetOut && !pwrEdge
    |-> pulseLen < PWR_RST_LEN)
    else $error("power-fail pulse too long");

endmodule // faxdw_decoder_watchdog

// ==== test/faxdw_fw_model.sv ====
// faxdw_fw_model: firmware side of the watchdog, kicking it at a fixed period.
// assumes the decoder's clk_sys; the bench drops enable to stop the kicks and let the watchdog expire.
`timescale 1ns/1ps
module faxdw_fw_model #(
  parameter int KICK_PERIOD = 20
) (
  input  wire logic clk_sys,
  input  wire logic enable,
  output logic      wdogKick
);
  logic [7:0] tick;

  // periodic watchdog service
  // period must stay well under the timeout, else the firmware itself faults
  always_ff @(posedge clk_sys) begin
    if (!enable) begin
      tick     <= 8'h00;
      wdogKick <= 1'b0;
    end else if (tick == 8'(KICK_PERIOD - 1)) begin
      tick     <= 8'h00;
      wdogKick <= 1'b1;
    end else begin
      tick     <= tick + 8'h01;
      wdogKick <= 1'b0;
    end
  end
endmodule // faxdw_fw_model

// ==== test/fax_address_decoder_watchdog_tb.sv ====
// fax_address_decoder_watchdog_tb: self-checking bench for the decoder and watchdog.
// assumes shortened counts: timeout 50, fault 4, power pulse 20 cycles.
`timescale 1ns/1ps
`define EXPECT(got, exp, msg) \
  begin totalChecks++; if ((got) !== (exp)) begin failures++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module fax_address_decoder_watchdog_tb;
  import faxdw_pkg::*;
  typedef struct {
    logic [15:0] addr; logic [5:0] bank; logic mreq;
    logic fSel; logic [18:0] fAddr; logic dSel; logic [9:0] dAddr;
  } faxdw_row_s;
  logic        clk_sys, rstn, cpuMreq, wdogKick, pwrFail, imgWe, kickEnable;
  logic [15:0] cpuAddr;
  logic [5:0]  flashBankIndex;
  logic [12:0] imgAddr;
  logic [7:0]  imgWdata, imgRdata;
  logic        flashSelN, dramSelN, watchdogFaultOutN, sysResetOut;
  logic [18:0] flashAddr;
  logic [9:0]  dramAddr;
  int          failures, totalChecks, n;
  faxdw_row_s  rows [14];

  faxdw_decoder_watchdog #(
    .WDOG_TIMEOUT(20'h00032), .WDOG_FAULT_LEN(20'h00004), .PWR_RST_LEN(24'h000014)
  ) u_faxdw_decoder_watchdog (
    .clk_sys(clk_sys), .rstn(rstn), .cpuAddr(cpuAddr), .cpuMreq(cpuMreq),
    .flashBankIndex(flashBankIndex), .wdogKick(wdogKick), .pwrFail(pwrFail),
    .imgAddr(imgAddr), .imgWe(imgWe), .imgWdata(imgWdata), .flashSelN(flashSelN),
    .flashAddr(flashAddr), .dramSelN(dramSelN), .dramAddr(dramAddr),
    .imgRdata(imgRdata), .watchdogFaultOutN(watchdogFaultOutN),
    .sysResetOut(sysResetOut));

  faxdw_fw_model #(.KICK_PERIOD(20)) u_faxdw_fw_model (
    .clk_sys(clk_sys), .enable(kickEnable), .wdogKick(wdogKick));

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one request driven after an edge, sampled at the next edge, registered answer checked 1 ns after that same edge
  task automatic access(input logic [15:0] a, input logic [5:0] b, input logic m);
    @(posedge clk_sys);
    cpuAddr        <= a;
    flashBankIndex <= b;
    cpuMreq        <= m;
    @(posedge clk_sys);
    #1;
  endtask

  // used-up bound counts as a mismatch and ends the run
  task automatic giveUp(input string what);
    failures++;
    $display("wrong value at %0t: timeout %s", $time, what);
    conclude();
  endtask

  initial begin
    rows = '{
      '{16'h0000, 6'h05, 1'b1, 1'b0, 19'h00000, 1'b1, 10'h000},
      '{16'h7FFF, 6'h05, 1'b1, 1'b0, 19'h07FFF, 1'b1, 10'h000},
      '{16'h8000, 6'h04, 1'b1, 1'b0, 19'h08000, 1'b1, 10'h000},
      '{16'h9FFF, 6'h3F, 1'b1, 1'b0, 19'h7FFFF, 1'b1, 10'h000},
      '{16'h8123, 6'h05, 1'b1, 1'b0, 19'h0A123, 1'b1, 10'h000},
      '{16'h8123, 6'h03, 1'b1, 1'b1, 19'h00000, 1'b1, 10'h000},
      '{16'hA000, 6'h05, 1'b1, 1'b1, 19'h00000, 1'b1, 10'h000},
      '{16'hF200, 6'h05, 1'b1, 1'b1, 19'h00000, 1'b0, 10'h000},
      '{16'hF3FF, 6'h05, 1'b1, 1'b1, 19'h00000, 1'b0, 10'h1FF},
      '{16'hF400, 6'h05, 1'b1, 1'b1, 19'h00000, 1'b1, 10'h000},
      '{16'hF600, 6'h05, 1'b1, 1'b1, 19'h00000, 1'b0, 10'h200},
      '{16'hF7FF, 6'h05, 1'b1, 1'b1, 19'h00000, 1'b0, 10'h3FF},
      '{16'hF800, 6'h05, 1'b1, 1'b1, 19'h00000, 1'b1, 10'h000},
      '{16'h0000, 6'h05, 1'b0, 1'b1, 19'h00000, 1'b1, 10'h000}};
    failures = 0; totalChecks = 0;
    rstn = 1'b0; cpuMreq = 1'b0; cpuAddr = 16'h0000; flashBankIndex = 6'h04;
    pwrFail = 1'b0; imgAddr = 13'h0000; imgWe = 1'b0; imgWdata = 8'h00;
    kickEnable = 1'b0;
    // reset held six cycles, idle values checked after the fifth, before release
    repeat (5) @(posedge clk_sys);
    #1;
    `EXPECT({flashSelN, dramSelN, watchdogFaultOutN, sysResetOut}, 4'hE, "reset outs")
    @(posedge clk_sys);
    rstn       <= 1'b1;
    kickEnable <= 1'b1;
    repeat (5) @(posedge clk_sys);
    $display("test reset done");

    // address map table, requests back to back
    foreach (rows[i]) begin
      access(rows[i].addr, rows[i].bank, rows[i].mreq);
      `EXPECT(flashSelN, rows[i].fSel, "flash select")
      `EXPECT(flashAddr, rows[i].fAddr, "flash address")
      `EXPECT(dramSelN, rows[i].dSel, "dram select")
      `EXPECT(dramAddr, rows[i].dAddr, "dram address")
    end
    `EXPECT(watchdogFaultOutN, 1'b1, "fault while serviced")
    $display("test address map done");

    // image memory: both ends of the 8 KB, written back to back then read
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      imgAddr  <= (k == 0) ? 13'h0000 : 13'h1FFF;
      imgWdata <= (k == 0) ? 8'hA5 : 8'h3C;
      imgWe    <= 1'b1;
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      imgWe   <= 1'b0;
      imgAddr <= (k == 0) ? 13'h0000 : 13'h1FFF;
      @(posedge clk_sys);
      #1;
      `EXPECT(imgRdata, (k == 0) ? 8'hA5 : 8'h3C, "image readback")
    end
    $display("test image memory done");

    // watchdog starved: expiry time, refusal during fault, fault length
    @(posedge clk_sys);
    kickEnable <= 1'b0;
    n = 0;
    while (watchdogFaultOutN !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 100) giveUp("watchdog");
    `EXPECT(n inside {[28:56]}, 1'b1, "expiry time")
    access(16'h0000, 6'h05, 1'b1);
    `EXPECT(flashSelN, 1'b1, "select during fault")
    n = 0;
    while (watchdogFaultOutN !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 20) giveUp("fault release");
    // four low cycles in all, two of them spent in the refused access above
    `EXPECT(n, 2, "fault length")
    @(posedge clk_sys);
    kickEnable <= 1'b1;
    $display("test watchdog done");

    // power interruption: pulse length and refusal in mid-pulse
    access(16'h0000, 6'h05, 1'b1);
    `EXPECT(flashSelN, 1'b0, "select after fault")
    @(posedge clk_sys);
    pwrFail <= 1'b1;
    n = 0;
    while (sysResetOut !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 10) giveUp("power pulse");
    n = 0;
    while (sysResetOut === 1'b1 && n < 40) begin
      if (n == 10) `EXPECT(flashSelN, 1'b1, "select during pulse")
      @(posedge clk_sys);
      #1;
      n++;
    end
    `EXPECT(n, 20, "power pulse length")
    // pin held high through the pulse; only its rising edge counts
    @(posedge clk_sys);
    pwrFail <= 1'b0;
    $display("test power fail done");
    conclude();
  end
endmodule // fax_address_decoder_watchdog_tb
